/* File: rtl/decoder_buffer_transfer_pointers.sv */
// buffer management and transfer pointer registers of the decoder
//
// How it works
// - nine-bit drive last area register
// - stop buffering after last area written
// - target differs from current: set mismatch
// - remaining block count decrements per block
// - transfer area starts, increments per block in 2048 mode, every 2 or 4 blocks in 1024/512 modes
// - block position steps in 512/1024 modes
// - block position ignored in other modes
// - counters readable at any time
// - manual byte count loads, reads remaining
// - stop buffering at subcode stop address
// - buffering area increments per sector in drive buffering mode only
// - transferable count decrements per block
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module decoder_buffer_transfer_pointers (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // decoder events
  input wire logic command_start,
  input wire logic sector_buffered,
  input wire logic subcode_written,
  input wire logic [buffer_ptr_pkg::ADDR_W-1:0] subcode_address,
  input wire logic header_valid,
  input wire logic [7:0] current_minute,
  input wire logic [7:0] current_second,
  input wire logic [7:0] current_block,
  // host transfer events
  input wire logic block_transferred,
  input wire logic byte_transferred,
  // pointers to the buffer side
  output logic buffering_allowed,
  output logic [buffer_ptr_pkg::AREA_W-1:0] buffering_area,
  output logic [buffer_ptr_pkg::AREA_W-1:0] transfer_area,
  output logic [buffer_ptr_pkg::POS_W-1:0] transfer_position,
  output logic [buffer_ptr_pkg::ADDR_W-1:0] manual_head_address,
  output logic [buffer_ptr_pkg::ADDR_W-1:0] manual_byte_count,
  // interrupt
  output logic irq
);
  import buffer_ptr_pkg::*;

  logic ack_q;
  logic [31:0] readdata_q;
  logic [31:0] rdata_d;
  logic [6:0] idx;
  logic wr;
  logic [7:0] wd;

  logic [7:0] control_q;
  logic [AREA_W-1:0] last_area_q;
  logic [7:0] tgt_minute_q;
  logic [7:0] tgt_second_q;
  logic [7:0] tgt_block_q;
  logic target_mismatch_flag_q;
  logic [BLOCKS_W-1:0] remaining_block_count_q;
  logic [AREA_W-1:0] transfer_area_pointer_q;
  logic [POS_W-1:0] transfer_block_position_q;
  logic [ADDR_W-1:0] manual_byte_count_q;
  logic [ADDR_W-1:0] manual_head_address_q;
  logic [ADDR_W-1:0] subcode_stop_address_q;
  logic [3:0] stop_hi_stage_q;
  logic [7:0] stop_mid_stage_q;
  logic [AVAIL_W-1:0] transferable_block_count_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_events;

  xfer_mode_t xfer_mode;
  cmd_mode_t cmd_mode;
  logic end_limit_enable;
  logic auto_block;
  logic area_advance;
  logic [POS_W-1:0] pos_next;
  logic mismatch_now;
  logic blocks_done;
  logic bytes_done;

  buffering_if bif ();

  assign idx = address[8:2];
  assign wd = writedata[7:0];
  assign end_limit_enable = control_q[CTRL_END_LIMIT_BIT];
  assign xfer_mode = xfer_mode_t'(control_q[CTRL_XFR_MODE_LSB +: 2]);
  assign cmd_mode = cmd_mode_t'(control_q[CTRL_CMD_LSB +: 2]);

  // one wait state per access; the write lands on the edge that ends it
  assign waitrequest = (read || write) && !ack_q;
  assign wr = write && ack_q && byteenable[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read || write) && !ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readdata_q <= '0;
    end else if (read && !ack_q) begin
      readdata_q <= rdata_d;
    end
  end
  assign readdata = readdata_q;

  // live counter readback, unmapped reads zero
  always_comb begin
    rdata_d = '0;
    if (idx == IDX_BUF_AREA_HI) begin
      rdata_d[0] = bif.area[AREA_W-1];
    end else if (idx == IDX_BUF_AREA_LO) begin
      rdata_d[7:0] = bif.area[7:0];
    end else if (idx == IDX_LAST_AREA_HI) begin
      rdata_d[0] = last_area_q[AREA_W-1];
    end else if (idx == IDX_LAST_AREA_LO) begin
      rdata_d[7:0] = last_area_q[7:0];
    end else if (idx == IDX_TGT_MINUTE) begin
      rdata_d[7:0] = tgt_minute_q;
    end else if (idx == IDX_TGT_SECOND) begin
      rdata_d[7:0] = tgt_second_q;
    end else if (idx == IDX_TGT_BLOCK) begin
      rdata_d[7:0] = tgt_block_q;
    end else if (idx == IDX_REM_HI) begin
      rdata_d[7:0] = remaining_block_count_q[23:16];
    end else if (idx == IDX_REM_MID) begin
      rdata_d[7:0] = remaining_block_count_q[15:8];
    end else if (idx == IDX_REM_LO) begin
      rdata_d[7:0] = remaining_block_count_q[7:0];
    end else if (idx == IDX_XFR_AREA_HI) begin
      rdata_d[0] = transfer_area_pointer_q[AREA_W-1];
    end else if (idx == IDX_XFR_AREA_LO) begin
      rdata_d[7:0] = transfer_area_pointer_q[7:0];
    end else if (idx == IDX_XFR_POS) begin
      rdata_d[POS_W-1:0] = transfer_block_position_q;
    end else if (idx == IDX_BYTE_CNT_HI) begin
      rdata_d[3:0] = manual_byte_count_q[19:16];
    end else if (idx == IDX_BYTE_CNT_MID) begin
      rdata_d[7:0] = manual_byte_count_q[15:8];
    end else if (idx == IDX_BYTE_CNT_LO) begin
      rdata_d[7:0] = manual_byte_count_q[7:0];
    end else if (idx == IDX_HEAD_HI) begin
      rdata_d[3:0] = manual_head_address_q[19:16];
    end else if (idx == IDX_HEAD_MID) begin
      rdata_d[7:0] = manual_head_address_q[15:8];
    end else if (idx == IDX_HEAD_LO) begin
      rdata_d[7:0] = manual_head_address_q[7:0];
    end else if (idx == IDX_STOP_HI) begin
      rdata_d[3:0] = subcode_stop_address_q[19:16];
    end else if (idx == IDX_STOP_MID) begin
      rdata_d[7:0] = subcode_stop_address_q[15:8];
    end else if (idx == IDX_STOP_LO) begin
      rdata_d[7:0] = subcode_stop_address_q[7:0];
    end else if (idx == IDX_AVAIL_HI) begin
      rdata_d[2:0] = transferable_block_count_q[10:8];
    end else if (idx == IDX_AVAIL_LO) begin
      rdata_d[7:0] = transferable_block_count_q[7:0];
    end else if (idx == IDX_CONTROL) begin
      rdata_d[7:0] = control_q;
    end else if (idx == IDX_STATUS) begin
      rdata_d[STAT_MISMATCH_BIT] = target_mismatch_flag_q;
      rdata_d[STAT_STOPPED_BIT] = bif.stopped;
    end else if (idx == IDX_IRQ_STATUS) begin
      rdata_d[IRQ_W-1:0] = irq_status_q;
    end else if (idx == IDX_IRQ_MASK) begin
      rdata_d[IRQ_W-1:0] = irq_mask_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      control_q <= CONTROL_RESET;
    end else if (wr && idx == IDX_CONTROL) begin
      control_q <= wd;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      last_area_q <= '0;
    end else if (wr && idx == IDX_LAST_AREA_HI) begin
      last_area_q[AREA_W-1] <= wd[0];
    end else if (wr && idx == IDX_LAST_AREA_LO) begin
      last_area_q[7:0] <= wd;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tgt_minute_q <= BYTE_RESET;
      tgt_second_q <= BYTE_RESET;
      tgt_block_q <= BYTE_RESET;
    end else if (wr && idx == IDX_TGT_MINUTE) begin
      tgt_minute_q <= wd;
    end else if (wr && idx == IDX_TGT_SECOND) begin
      tgt_second_q <= wd;
    end else if (wr && idx == IDX_TGT_BLOCK) begin
      tgt_block_q <= wd;
    end
  end

  assign mismatch_now = header_valid && ({current_minute, current_second, current_block} !=
                        {tgt_minute_q, tgt_second_q, tgt_block_q});

  always_ff @(posedge clk) begin
    if (rst) begin
      target_mismatch_flag_q <= 1'b0;
    end else if (header_valid) begin
      target_mismatch_flag_q <= mismatch_now;
    end
  end

  assign blocks_done = block_transferred && (remaining_block_count_q == BLOCKS_W'(1));

  always_ff @(posedge clk) begin
    if (rst) begin
      remaining_block_count_q <= '0;
    end else if (wr && idx == IDX_REM_HI) begin
      remaining_block_count_q[23:16] <= wd;
    end else if (wr && idx == IDX_REM_MID) begin
      remaining_block_count_q[15:8] <= wd;
    end else if (wr && idx == IDX_REM_LO) begin
      remaining_block_count_q[7:0] <= wd;
    end else if (block_transferred && remaining_block_count_q != '0) begin
      remaining_block_count_q <= remaining_block_count_q - 1'b1;
    end
  end

  always_comb begin
    case (xfer_mode)
      XFR_AUTO_2048: begin
        area_advance = 1'b1;
        pos_next = transfer_block_position_q;
      end
      XFR_AUTO_512: begin
        area_advance = (transfer_block_position_q == 2'h3);
        pos_next = transfer_block_position_q + 1'b1;
      end
      XFR_AUTO_1024: begin
        area_advance = transfer_block_position_q[0];
        pos_next = {transfer_block_position_q[1], ~transfer_block_position_q[0]};
      end
      default: begin
        area_advance = 1'b0;
        pos_next = transfer_block_position_q;
      end
    endcase
  end
  assign auto_block = block_transferred && (xfer_mode != XFR_MANUAL);

  always_ff @(posedge clk) begin
    if (rst) begin
      transfer_area_pointer_q <= '0;
    end else if (wr && idx == IDX_XFR_AREA_HI) begin
      transfer_area_pointer_q[AREA_W-1] <= wd[0];
    end else if (wr && idx == IDX_XFR_AREA_LO) begin
      transfer_area_pointer_q[7:0] <= wd;
    end else if (auto_block && area_advance) begin
      transfer_area_pointer_q <= transfer_area_pointer_q + 1'b1;
    end
  end

  // only two bits are kept, upper bits of the write are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      transfer_block_position_q <= '0;
    end else if (wr && idx == IDX_XFR_POS) begin
      transfer_block_position_q <= wd[POS_W-1:0];
    end else if (auto_block) begin
      transfer_block_position_q <= pos_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      transferable_block_count_q <= '0;
    end else if (wr && idx == IDX_AVAIL_HI) begin
      transferable_block_count_q[10:8] <= wd[2:0];
    end else if (wr && idx == IDX_AVAIL_LO) begin
      transferable_block_count_q[7:0] <= wd;
    end else if (block_transferred && transferable_block_count_q != '0) begin
      transferable_block_count_q <= transferable_block_count_q - 1'b1;
    end
  end

  assign bytes_done = byte_transferred && (xfer_mode == XFR_MANUAL) && (manual_byte_count_q == ADDR_W'(1));

  always_ff @(posedge clk) begin
    if (rst) begin
      manual_byte_count_q <= '0;
    end else if (wr && idx == IDX_BYTE_CNT_HI) begin
      manual_byte_count_q[19:16] <= wd[3:0];
    end else if (wr && idx == IDX_BYTE_CNT_MID) begin
      manual_byte_count_q[15:8] <= wd;
    end else if (wr && idx == IDX_BYTE_CNT_LO) begin
      manual_byte_count_q[7:0] <= wd;
    end else if (byte_transferred && xfer_mode == XFR_MANUAL && manual_byte_count_q != '0) begin
      manual_byte_count_q <= manual_byte_count_q - 1'b1;
    end
  end

  // upper nibble of the high byte is not stored
  always_ff @(posedge clk) begin
    if (rst) begin
      manual_head_address_q <= '0;
    end else if (wr && idx == IDX_HEAD_HI) begin
      manual_head_address_q[19:16] <= wd[3:0];
    end else if (wr && idx == IDX_HEAD_MID) begin
      manual_head_address_q[15:8] <= wd;
    end else if (wr && idx == IDX_HEAD_LO) begin
      manual_head_address_q[7:0] <= wd;
    end else if (byte_transferred && xfer_mode == XFR_MANUAL && manual_byte_count_q != '0) begin
      manual_head_address_q <= manual_head_address_q + 1'b1;
    end
  end

  // stop address commits on low byte
  // staging avoids a half-written address ever being compared
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_hi_stage_q <= '0;
      stop_mid_stage_q <= BYTE_RESET;
      subcode_stop_address_q <= '0;
    end else if (wr && idx == IDX_STOP_HI) begin
      stop_hi_stage_q <= wd[3:0];
    end else if (wr && idx == IDX_STOP_MID) begin
      stop_mid_stage_q <= wd;
    end else if (wr && idx == IDX_STOP_LO) begin
      subcode_stop_address_q <= {stop_hi_stage_q, stop_mid_stage_q, wd};
    end
  end

  assign bif.end_limit = end_limit_enable;
  assign bif.cmd = cmd_mode;
  assign bif.last_area = last_area_q;
  assign bif.stop_addr = subcode_stop_address_q;
  assign bif.sector_done = sector_buffered;
  assign bif.sub_wr = subcode_written;
  assign bif.sub_addr = subcode_address;
  assign bif.cmd_start = command_start;
  assign bif.area_wr_hi = wr && idx == IDX_BUF_AREA_HI;
  assign bif.area_wr_lo = wr && idx == IDX_BUF_AREA_LO;
  assign bif.wdata = wd;

  buffering_stop_unit u_stop (
    .clk(clk),
    .rst(rst),
    .bif(bif)
  );

  // sticky events; a new event beats a write-one clear
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_MISMATCH] = mismatch_now;
    irq_events[IRQ_STOPPED] = bif.stop_event;
    irq_events[IRQ_BLOCKS_DONE] = blocks_done;
    irq_events[IRQ_BYTES_DONE] = bytes_done;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_q <= '0;
    end else if (wr && idx == IDX_IRQ_STATUS) begin
      irq_status_q <= (irq_status_q & ~wd[IRQ_W-1:0]) | irq_events;
    end else begin
      irq_status_q <= irq_status_q | irq_events;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (wr && idx == IDX_IRQ_MASK) begin
      irq_mask_q <= wd[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);
  assign buffering_allowed = !bif.stopped;
  assign buffering_area = bif.area;
  assign transfer_area = transfer_area_pointer_q;
  assign transfer_position = transfer_block_position_q;
  assign manual_head_address = manual_head_address_q;
  assign manual_byte_count = manual_byte_count_q;
endmodule

/* File: rtl/buffer_ptr_pkg.sv */
// constants and types of the buffer and transfer pointer block
package buffer_ptr_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [6:0] IDX_BUF_AREA_HI = 7'h20;
  localparam logic [6:0] IDX_BUF_AREA_LO = 7'h21;
  localparam logic [6:0] IDX_LAST_AREA_HI = 7'h24;
  localparam logic [6:0] IDX_LAST_AREA_LO = 7'h25;
  localparam logic [6:0] IDX_TGT_MINUTE = 7'h27;
  localparam logic [6:0] IDX_TGT_SECOND = 7'h28;
  localparam logic [6:0] IDX_TGT_BLOCK = 7'h29;
  localparam logic [6:0] IDX_REM_HI = 7'h2B;
  localparam logic [6:0] IDX_REM_MID = 7'h2C;
  localparam logic [6:0] IDX_REM_LO = 7'h2D;
  localparam logic [6:0] IDX_XFR_AREA_HI = 7'h2E;
  localparam logic [6:0] IDX_XFR_AREA_LO = 7'h2F;
  localparam logic [6:0] IDX_XFR_POS = 7'h31;
  localparam logic [6:0] IDX_BYTE_CNT_HI = 7'h33;
  localparam logic [6:0] IDX_BYTE_CNT_MID = 7'h34;
  localparam logic [6:0] IDX_BYTE_CNT_LO = 7'h35;
  localparam logic [6:0] IDX_HEAD_HI = 7'h37;
  localparam logic [6:0] IDX_HEAD_MID = 7'h38;
  localparam logic [6:0] IDX_HEAD_LO = 7'h39;
  localparam logic [6:0] IDX_STOP_HI = 7'h3B;
  localparam logic [6:0] IDX_STOP_MID = 7'h3C;
  localparam logic [6:0] IDX_STOP_LO = 7'h3D;
  localparam logic [6:0] IDX_AVAIL_HI = 7'h46;
  localparam logic [6:0] IDX_AVAIL_LO = 7'h47;
  localparam logic [6:0] IDX_CONTROL = 7'h60;
  localparam logic [6:0] IDX_STATUS = 7'h61;
  localparam logic [6:0] IDX_IRQ_STATUS = 7'h62;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h63;

  // widths
  localparam int AREA_W = 9;
  localparam int ADDR_W = 20;
  localparam int BLOCKS_W = 24;
  localparam int AVAIL_W = 11;
  localparam int POS_W = 2;
  localparam int IRQ_W = 4;

  // field positions
  localparam int CTRL_END_LIMIT_BIT = 1;
  localparam int CTRL_XFR_MODE_LSB = 2;
  localparam int CTRL_CMD_LSB = 4;
  localparam int STAT_MISMATCH_BIT = 0;
  localparam int STAT_STOPPED_BIT = 1;
  localparam int IRQ_MISMATCH = 0;
  localparam int IRQ_STOPPED = 1;
  localparam int IRQ_BLOCKS_DONE = 2;
  localparam int IRQ_BYTES_DONE = 3;

  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

  typedef enum logic [1:0] {
    XFR_MANUAL = 2'b00,
    XFR_AUTO_2048 = 2'b01,
    XFR_AUTO_512 = 2'b10,
    XFR_AUTO_1024 = 2'b11
  } xfer_mode_t;

  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_DRIVE_BUF = 2'b01,
    CMD_SUBCODE_BUF = 2'b10,
    CMD_MONITOR = 2'b11
  } cmd_mode_t;

endpackage

/* File: rtl/buffering_if.sv */
// signals between the register side and the buffering stop unit
`timescale 1ns/100ps
interface buffering_if;
  import buffer_ptr_pkg::*;
  logic end_limit;
  cmd_mode_t cmd;
  logic [AREA_W-1:0] last_area;
  logic [ADDR_W-1:0] stop_addr;
  logic sector_done;
  logic sub_wr;
  logic [ADDR_W-1:0] sub_addr;
  logic cmd_start;
  logic area_wr_hi;
  logic area_wr_lo;
  logic [7:0] wdata;
  logic [AREA_W-1:0] area;
  logic stopped;
  logic stop_event;

  modport ctrl (
    output end_limit, cmd, last_area, stop_addr, sector_done, sub_wr, sub_addr,
    output cmd_start, area_wr_hi, area_wr_lo, wdata,
    input area, stopped, stop_event
  );
  modport unit (
    input end_limit, cmd, last_area, stop_addr, sector_done, sub_wr, sub_addr,
    input cmd_start, area_wr_hi, area_wr_lo, wdata,
    output area, stopped, stop_event
  );
endinterface

/* File: rtl/buffering_stop_unit.sv */
// buffering area pointer and end-limit stop logic
`timescale 1ns/100ps
module buffering_stop_unit (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to register side
  buffering_if.unit bif
);
  import buffer_ptr_pkg::*;

  logic [AREA_W-1:0] area_q;
  logic stopped_q;
  logic drive_hit;
  logic sub_hit;

  assign drive_hit = bif.end_limit && (bif.cmd == CMD_DRIVE_BUF) && bif.sector_done && (area_q == bif.last_area);
  assign sub_hit = bif.end_limit && (bif.cmd == CMD_SUBCODE_BUF) && bif.sub_wr && (bif.sub_addr == bif.stop_addr);

  // a match in the same cycle as a restart keeps the stop
  always_ff @(posedge clk) begin
    if (rst) begin
      stopped_q <= 1'b0;
    end else if (drive_hit || sub_hit) begin
      stopped_q <= 1'b1;
    end else if (bif.cmd_start || bif.area_wr_hi || bif.area_wr_lo) begin
      stopped_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      area_q <= '0;
    end else if (bif.area_wr_hi) begin
      area_q[AREA_W-1] <= bif.wdata[0];
    end else if (bif.area_wr_lo) begin
      area_q[7:0] <= bif.wdata;
    end else if (bif.sector_done && bif.cmd == CMD_DRIVE_BUF && !stopped_q && !drive_hit) begin
      area_q <= area_q + 1'b1;
    end
  end

  assign bif.area = area_q;
  assign bif.stopped = stopped_q;
  assign bif.stop_event = (drive_hit || sub_hit) && !stopped_q;
endmodule

/* File: sim/decoder_buffer_transfer_pointers_sva.sv */
// port assertions of the buffer and transfer pointer block
`timescale 1ns/100ps
module decoder_buffer_transfer_pointers_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // events
  input wire logic command_start,
  input wire logic sector_buffered,
  input wire logic block_transferred,
  input wire logic byte_transferred,
  // pointers
  input wire logic buffering_allowed,
  input wire logic [8:0] buffering_area,
  input wire logic [8:0] transfer_area,
  input wire logic [1:0] transfer_position,
  input wire logic [19:0] manual_head_address,
  input wire logic [19:0] manual_byte_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  a_bus_wait: assert property ($rose(read || write) |-> s_one_wait)
    else $error("bus wait state wrong");
  a_stop_freeze: assert property (!buffering_allowed && !write |=> $stable(buffering_area))
    else $error("stopped area moved");
  a_stop_holds: assert property (!buffering_allowed && !command_start && !write |=> !buffering_allowed)
    else $error("stop released early");
  a_xfr_still: assert property (!block_transferred && !write |=> $stable({transfer_area, transfer_position}))
    else $error("transfer pointer moved alone");
  a_byte_pair: assert property (!write |=> $changed(manual_byte_count) == $changed(manual_head_address))
    else $error("count and head out of step");
  a_byte_step: assert property ($changed(manual_byte_count) && !$past(write)
    |-> $past(byte_transferred) && manual_byte_count == 20'($past(manual_byte_count) - 1))
    else $error("byte count step wrong");
  a_area_step: assert property ($changed(transfer_area) && !$past(write)
    |-> $past(block_transferred) && transfer_area == 9'($past(transfer_area) + 1))
    else $error("transfer area step wrong");
  a_buf_step: assert property ($changed(buffering_area) && !$past(write)
    |-> $past(sector_buffered) && buffering_area == 9'($past(buffering_area) + 1))
    else $error("buffering area step wrong");
  a_pos_step: assert property ($changed(transfer_position) && !$past(write) |-> $past(block_transferred))
    else $error("position moved alone");
endmodule
bind decoder_buffer_transfer_pointers decoder_buffer_transfer_pointers_sva chk (.clk(clk), .rst(rst),
  .read(read), .write(write), .waitrequest(waitrequest), .command_start(command_start),
  .sector_buffered(sector_buffered), .block_transferred(block_transferred),
  .byte_transferred(byte_transferred), .buffering_allowed(buffering_allowed),
  .buffering_area(buffering_area), .transfer_area(transfer_area), .transfer_position(transfer_position),
  .manual_head_address(manual_head_address), .manual_byte_count(manual_byte_count));

/* File: sim/decoder_buffer_transfer_pointers_test.sv */
// self-checking bench of the buffer and transfer pointer block
`timescale 1ns/100ps
module decoder_buffer_transfer_pointers_test;
  import buffer_ptr_pkg::*;
  logic clk = 0, rst = 1, read = 0, write = 0, waitrequest, buffering_allowed, irq;
  logic [8:0] address = 0;
  logic [31:0] writedata = 0, readdata, got;
  logic [5:0] evt = 0;
  logic [7:0] cm = 0, cs = 0, cb = 0, x;
  logic [ADDR_W-1:0] sa = 0, head, cnt, h, v;
  logic [AREA_W-1:0] area, xarea;
  logic [POS_W-1:0] xpos;
  logic [10:0] ap;
  logic [7:0] tg [3];
  logic [6:0] ri [15] = '{7'h24, 7'h25, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h31,
    7'h33, 7'h34, 7'h35, 7'h37, 7'h38, 7'h39, 7'h46};
  logic [7:0] rm [15] = '{8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'hFF, 8'h03,
    8'h0F, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h07};
  int n_fail = 0, samples_checked = 0, n, m;
  always #5 clk = ~clk;
  decoder_buffer_transfer_pointers dut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .command_start(evt[5]), .sector_buffered(evt[2]),
    .subcode_written(evt[3]), .subcode_address(sa), .header_valid(evt[4]), .current_minute(cm),
    .current_second(cs), .current_block(cb), .block_transferred(evt[0]), .byte_transferred(evt[1]),
    .buffering_allowed(buffering_allowed), .buffering_area(area), .transfer_area(xarea),
    .transfer_position(xpos), .manual_head_address(head), .manual_byte_count(cnt), .irq(irq));
  task finish_test;
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // request held until the edge where waitrequest is low
  task bus(input logic r, input logic [6:0] i, input logic [7:0] d);
    int k;
    @(posedge clk);
    address <= {i, 2'b00};
    read <= r;
    write <= !r;
    writedata <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    if (waitrequest !== 1'b0) begin
      n_fail++;
      finish_test();
    end
    // write lands and read data is taken at this edge
    got = readdata;
    read <= 0;
    write <= 0;
    // outputs are looked at once the write has settled
    @(negedge clk);
  endtask
  task wr(input logic [6:0] i, input logic [7:0] d);
    bus(0, i, d);
  endtask
  task rd(input logic [6:0] i, input logic [7:0] e);
    bus(1, i, 8'h00);
    chk($sformatf("reg %h", i), {24'h0, e}, got);
  endtask
  // high, middle, then low byte
  task wr3(input logic [6:0] i, input logic [19:0] w);
    wr(i, {4'h0, w[19:16]});
    wr(7'(i + 1), w[15:8]);
    wr(7'(i + 2), w[7:0]);
  endtask
  task ev(input logic [5:0] k);
    @(posedge clk);
    evt <= k;
    @(posedge clk);
    evt <= 0;
    @(negedge clk);
  endtask
  // next {area, position} after one block
  function automatic logic [10:0] step(input logic [1:0] md, input logic [10:0] q);
    case (md)
      2'd1: return 11'(q + 11'h004);
      2'd2: return 11'(q + 11'h001);
      2'd3: return {9'(q[10:2] + q[0]), q[1], ~q[0]};
      default: return q;
    endcase
  endfunction
  initial begin
    void'($urandom(51));
    repeat (3) @(posedge clk);
    rst <= 0;
    chk("allowed", 1, buffering_allowed);
    rd(IDX_XFR_POS, 8'h00);
    wr(7'h7F, 8'hA5);
    rd(7'h7F, 8'h00);
    foreach (ri[j]) begin
      x = 8'($urandom()) & rm[j];
      wr(ri[j], x);
      rd(ri[j], x);
    end
    wr(IDX_IRQ_MASK, 8'h0F);
    foreach (tg[j]) begin
      n = $urandom_range(j == 0 ? 99 : (j == 1 ? 59 : 74));
      tg[j] = {4'(n / 10), 4'(n % 10)};
      wr(7'(IDX_TGT_MINUTE + j), tg[j]);
      rd(7'(IDX_TGT_MINUTE + j), tg[j]);
    end
    @(posedge clk);
    {cm, cs, cb} <= {tg[0], tg[1], tg[2]};
    ev(6'h10);
    rd(IDX_STATUS, 8'h00);
    @(posedge clk);
    cb <= tg[2] ^ 8'h01;
    ev(6'h10);
    rd(IDX_STATUS, 8'h01);
    chk("irq", 1, irq);
    wr(IDX_IRQ_STATUS, 8'h01);
    chk("irq", 0, irq);
    for (m = 0; m < 4; m++) begin
      ap = 11'($urandom());
      wr(IDX_CONTROL, {4'h0, 2'(m), 2'b00});
      wr(IDX_XFR_AREA_HI, {7'h0, ap[10]});
      wr(IDX_XFR_AREA_LO, ap[9:2]);
      wr(IDX_XFR_POS, {6'h0, ap[1:0]});
      wr(IDX_REM_HI, 8'h00);
      wr(IDX_REM_MID, 8'h01);
      wr(IDX_REM_LO, 8'h00);
      wr(IDX_AVAIL_LO, 8'h10);
      n = $urandom_range(6, 1);
      repeat (n) begin
        ev(6'h01);
        ap = step(2'(m), ap);
      end
      chk("area", 32'(ap[10:2]), 32'(xarea));
      chk("pos", 32'(ap[1:0]), 32'(xpos));
      rd(IDX_REM_LO, 8'(256 - n));
      rd(IDX_REM_MID, 8'h00);
      rd(IDX_AVAIL_LO, 8'(16 - n));
    end
    wr(IDX_CONTROL, 8'h00);
    h = 20'($urandom());
    n = $urandom_range(8, 2);
    if (n == 3) h[0] = 1'b0;
    wr3(IDX_HEAD_HI, h);
    wr3(IDX_BYTE_CNT_HI, 20'(n));
    repeat (n + 1) ev(6'h02);
    chk("head", 32'(20'(h + n)), 32'(head));
    chk("count", 0, 32'(cnt));
    chk("irq", 1, irq);
    wr(IDX_IRQ_STATUS, 8'h0F);
    wr(IDX_CONTROL, 8'h12);
    wr(IDX_BUF_AREA_HI, 8'h01);
    wr(IDX_BUF_AREA_LO, 8'hFE);
    wr(IDX_LAST_AREA_HI, 8'h01);
    wr(IDX_LAST_AREA_LO, 8'hFF);
    ev(6'h04);
    chk("buf area", 32'h1FF, 32'(area));
    chk("allowed", 1, buffering_allowed);
    repeat (2) ev(6'h04);
    chk("buf area", 32'h1FF, 32'(area));
    chk("allowed", 0, buffering_allowed);
    rd(IDX_STATUS, 8'h03);
    ev(6'h20);
    chk("allowed", 1, buffering_allowed);
    wr(IDX_IRQ_STATUS, 8'h0F);
    v = 20'($urandom());
    wr3(IDX_STOP_HI, v);
    rd(IDX_STOP_LO, v[7:0]);
    @(posedge clk);
    sa <= v;
    wr(IDX_CONTROL, 8'h20);
    ev(6'h08);
    chk("allowed", 1, buffering_allowed);
    wr(IDX_CONTROL, 8'h22);
    @(posedge clk);
    sa <= v ^ 20'h00001;
    ev(6'h08);
    chk("allowed", 1, buffering_allowed);
    @(posedge clk);
    sa <= v;
    ev(6'h08);
    chk("allowed", 0, buffering_allowed);
    chk("irq", 1, irq);
    wr(IDX_IRQ_MASK, 8'h00);
    chk("irq", 0, irq);
    ev(6'h20);
    chk("allowed", 1, buffering_allowed);
    finish_test();
  end
endmodule
